/* rtl/hs_switch_pkg.sv */
// constants shared by the octal switch control logic and its serial link
// assumes: single-byte registers, 7-bit register address, 24-bit link word
package hs_switch_pkg;

  localparam int NUM_CH = 8;
  localparam int ADDR_W = 7;
  localparam int LINK_W = 24;
  localparam int CNT_W = 6;

  // register map (read data is one byte)
  localparam logic [ADDR_W-1:0] ADDR_OUTPUT_STATE = 7'h00;
  localparam logic [ADDR_W-1:0] ADDR_SWITCH_STATE = 7'h01;
  localparam logic [ADDR_W-1:0] ADDR_FAULT_STATUS = 7'h02;
  localparam logic [ADDR_W-1:0] ADDR_FAULT_SELECT = 7'h03;
  localparam logic [ADDR_W-1:0] ADDR_PIN_STATUS = 7'h04;

  // power-on values
  localparam logic [7:0] RST_OUTPUT_STATE = 8'h00;
  localparam logic [7:0] RST_FAULT_SELECT = 8'hFF;
  localparam logic [LINK_W-1:0] RST_TX_WORD = 24'h000000;

  // frame layout: header is write flag, address, data; crc byte trails
  localparam int HDR_WR_POS = 15;
  localparam int HDR_ADDR_MSB = 14;
  localparam int HDR_ADDR_LSB = 8;
  localparam int HDR_DATA_MSB = 7;
  localparam logic [CNT_W-1:0] FRAME_BITS_PLAIN = 6'h10;
  localparam logic [CNT_W-1:0] FRAME_BITS_CRC = 6'h18;
  localparam logic [CNT_W-1:0] CNT_MAX = 6'h3F;

  // crc over the 16 header bits, msb first
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;

  function automatic logic [7:0] crc8(input logic [15:0] data);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      if (c[7] ^ data[i]) begin
        c = {c[6:0], 1'b0} ^ CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction : crc8

endpackage : hs_switch_pkg

/* rtl/spi_link.sv */
// serial shift engine on the host's serial clock
// assumes: no clock edges while csN is high; csN falls before the first
// rising edge and the host samples misoOut on rising edges
`timescale 1ns/1ns
`default_nettype none

module spi_link (
  input wire logic spiClk,
  input wire logic srst,
  input wire logic csN,
  input wire logic mosi,
  input wire logic [hs_switch_pkg::LINK_W-1:0] txWord,
  output logic [hs_switch_pkg::LINK_W-1:0] rxWord,
  output logic [hs_switch_pkg::CNT_W-1:0] bitCount,
  output logic noClocks,
  output logic misoOut,
  output logic misoOe
);
  import hs_switch_pkg::*;

  typedef struct packed {
    logic seenTgl;
    logic [CNT_W-1:0] cnt;
    logic [LINK_W-1:0] rx;
    logic [LINK_W-1:0] tx;
  } link_t;

  link_t state_q;
  link_t state_d;
  logic frameTgl_q;
  logic firstEdge;

  ////////////////////////////////////////////////////////////////////////////
  // frame marker: toggles at each frame start, so the counter restarts on
  // the first edge and keeps its value after csN rises for the core to read
  always_ff @(negedge csN or posedge srst) begin
    if (srst) begin
      frameTgl_q <= 1'b0;
    end else begin
      frameTgl_q <= ~frameTgl_q;
    end
  end

  assign firstEdge = state_q.seenTgl != frameTgl_q;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_d = state_q;
    state_d.seenTgl = frameTgl_q;
    if (firstEdge) begin
      state_d.cnt = 6'h01;
      state_d.tx = {txWord[LINK_W-2:0], 1'b0};
    end else begin
      if (state_q.cnt != CNT_MAX) begin
        state_d.cnt = state_q.cnt + 6'h01;
      end
      state_d.tx = {state_q.tx[LINK_W-2:0], 1'b0};
    end
    state_d.rx = {state_q.rx[LINK_W-2:0], mosi};
  end

  always_ff @(posedge spiClk or posedge srst) begin
    if (srst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // first bit comes straight from the held answer word before any edge
  assign misoOut = firstEdge ? txWord[LINK_W-1] : state_q.tx[LINK_W-1];
  assign misoOe = ~csN;
  assign rxWord = state_q.rx;
  assign bitCount = state_q.cnt;
  assign noClocks = firstEdge;

endmodule : spi_link

`default_nettype wire

/* rtl/hs_switch_ctrl.sv */
// control pins, register file and switch output update of an octal switch
// assumes: pins and supply monitors are asynchronous to core_clk; the host
// keeps csN high at least 200 ns between frames
`timescale 1ns/1ns
`default_nettype none

module hs_switch_ctrl (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic spiClk,
  input wire logic csN,
  input wire logic mosi,
  output logic misoOut,
  output logic misoOe,
  input wire logic enableIn,
  input wire logic updateStrobe,
  input wire logic crcSelectInput,
  input wire logic logicSupplyOk,
  input wire logic ioSupplyOk,
  input wire logic regSupplyOk,
  input wire logic [hs_switch_pkg::NUM_CH-1:0] faultConditions,
  output logic [hs_switch_pkg::NUM_CH-1:0] switchOn,
  output logic [hs_switch_pkg::NUM_CH-1:0] switchOe,
  output logic faultOe,
  output logic commErrorOutputOe,
  output logic readyOe
);
  import hs_switch_pkg::*;

  typedef struct packed {
    logic [1:0] enSync;
    logic [2:0] strobeSync;
    logic [1:0] crcSync;
    logic [2:0] csSync;
    logic [1:0] logicOkSync;
    logic [1:0] ioOkSync;
    logic [1:0] regOkSync;
    logic [NUM_CH-1:0] faultSync1;
    logic [NUM_CH-1:0] faultSync2;
    logic [7:0] outState;
    logic [7:0] faultSel;
    logic [NUM_CH-1:0] applied;
    logic [NUM_CH-1:0] switchOn;
    logic [NUM_CH-1:0] switchOe;
    logic faultOe;
    logic commErr;
    logic readyOe;
    logic [LINK_W-1:0] txWord;
  } core_t;

  core_t state_q;
  core_t state_d;

  logic [LINK_W-1:0] rxWord;
  logic [CNT_W-1:0] bitCount;
  logic noClocks;
  logic enS;
  logic strobeS;
  logic strobeRise;
  logic crcS;
  logic regS;
  logic frameEnd;
  logic [CNT_W-1:0] frameLen;
  logic [15:0] header;
  logic crcOk;
  logic frameOk;
  logic isWrite;
  logic [ADDR_W-1:0] addr;
  logic [7:0] wData;
  logic [15:0] resp;
  logic faultHit;

  ////////////////////////////////////////////////////////////////////////////
  // serial link on its own clock; words are read only after csN has risen,
  // when the link clock has stopped and the shift state is frozen
  spi_link link (
    .spiClk(spiClk),
    .srst(srst),
    .csN(csN),
    .mosi(mosi),
    .txWord(state_q.txWord),
    .rxWord(rxWord),
    .bitCount(bitCount),
    .noClocks(noClocks),
    .misoOut(misoOut),
    .misoOe(misoOe)
  );

  function automatic logic [7:0] readReg(input logic [ADDR_W-1:0] a,
                                         input core_t s);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      ADDR_OUTPUT_STATE: r = s.outState;
      ADDR_SWITCH_STATE: r = s.switchOn;
      ADDR_FAULT_STATUS: r = s.faultSync2;
      ADDR_FAULT_SELECT: r = s.faultSel;
      ADDR_PIN_STATUS: r = {4'h0, s.enSync[1], s.strobeSync[1],
                            s.crcSync[1], s.commErr};
      default: r = 8'h00;
    endcase
    return r;
  endfunction : readReg

  ////////////////////////////////////////////////////////////////////////////
  // synchronised pin levels; only stage [1] and later are looked at
  assign enS = state_q.enSync[1];
  assign strobeS = state_q.strobeSync[1];
  assign strobeRise = state_q.strobeSync[1] & ~state_q.strobeSync[2];
  assign crcS = state_q.crcSync[1];
  assign regS = state_q.regOkSync[1];
  assign frameEnd = state_q.csSync[1] & ~state_q.csSync[2];
  assign faultHit = |(state_q.faultSync2 & state_q.faultSel);

  // frame check: exact length, at least one clock, crc when selected
  assign frameLen = crcS ? FRAME_BITS_CRC : FRAME_BITS_PLAIN;
  assign header = crcS ? rxWord[LINK_W-1:8] : rxWord[15:0];
  assign crcOk = ~crcS || (crc8(rxWord[LINK_W-1:8]) == rxWord[7:0]);
  assign frameOk = ~noClocks && (bitCount == frameLen) && crcOk;
  assign isWrite = header[HDR_WR_POS];
  assign addr = header[HDR_ADDR_MSB:HDR_ADDR_LSB];
  assign wData = header[HDR_DATA_MSB:0];
  assign resp = {isWrite, addr, isWrite ? wData : readReg(addr, state_q)};

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_d = state_q;
    state_d.enSync = {state_q.enSync[0], enableIn};
    state_d.strobeSync = {state_q.strobeSync[1:0], updateStrobe};
    state_d.crcSync = {state_q.crcSync[0], crcSelectInput};
    state_d.csSync = {state_q.csSync[1:0], csN};
    state_d.logicOkSync = {state_q.logicOkSync[0], logicSupplyOk};
    state_d.ioOkSync = {state_q.ioOkSync[0], ioSupplyOk};
    state_d.regOkSync = {state_q.regOkSync[0], regSupplyOk};
    state_d.faultSync1 = faultConditions;
    state_d.faultSync2 = state_q.faultSync1;

    // register access happens once per frame, after csN returns high
    if (frameEnd) begin
      if (frameOk) begin
        if (isWrite && addr == ADDR_OUTPUT_STATE) begin
          state_d.outState = wData;
        end
        if (isWrite && addr == ADDR_FAULT_SELECT) begin
          state_d.faultSel = wData;
        end
        state_d.commErr = 1'b0;
        // answer goes out in the next frame, with crc when selected
        state_d.txWord = crcS ? {resp, crc8(resp)} : {resp, 8'h00};
      end else begin
        state_d.commErr = 1'b1;
      end
    end

    // outputs hold while strobe is low; edge or high level takes new state
    if (strobeRise) begin
      state_d.applied = state_d.outState;
    end else if (strobeS) begin
      state_d.applied = state_d.outState;
    end else begin
      state_d.applied = state_q.applied;
    end

    // a drop of the register supply wins over any access in flight
    if (~regS) begin
      state_d.outState = RST_OUTPUT_STATE;
      state_d.faultSel = RST_FAULT_SELECT;
      state_d.applied = '0;
      state_d.commErr = 1'b0;
      state_d.txWord = RST_TX_WORD;
    end

    // enable low forces every driver off and undriven, whatever else is set
    if (enS) begin
      state_d.switchOn = state_d.applied;
      state_d.switchOe = '1;
    end else begin
      state_d.switchOn = '0;
      state_d.switchOe = '0;
    end

    state_d.faultOe = faultHit;
    state_d.readyOe = ~(state_q.logicOkSync[1] & state_q.ioOkSync[1]
                        & regS);
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_q <= '0;
      state_q.outState <= RST_OUTPUT_STATE;
      state_q.faultSel <= RST_FAULT_SELECT;
      state_q.readyOe <= 1'b1;
      state_q.txWord <= RST_TX_WORD;
      state_q.csSync <= 3'h7;
      // strobe pin idles high on its pullup: start high, no false edge
      state_q.strobeSync <= 3'h7;
    end else begin
      state_q <= state_d;
    end
  end

  assign switchOn = state_q.switchOn;
  assign switchOe = state_q.switchOe;
  assign faultOe = state_q.faultOe;
  assign commErrorOutputOe = state_q.commErr;
  assign readyOe = state_q.readyOe;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence strobeEdgeSeq;
    !strobeS ##1 strobeS;
  endsequence

  sequence badFrameSeq;
    frameEnd && !frameOk && regS;
  endsequence

  AST_EN_OFF: assert property (
    !enS |=> (switchOe == '0 && switchOn == '0))
    else $error("drivers not off while enable low");

  AST_SYNC_LOAD: assert property (
    strobeEdgeSeq |=> (state_q.applied == state_q.outState))
    else $error("strobe edge did not load output state");

  AST_HOLD_LOW: assert property (
    (!strobeS && regS) |=> (state_q.applied == $past(state_q.applied)))
    else $error("outputs changed while strobe low");

  AST_TRANSPARENT: assert property (
    (strobeS && regS && frameEnd && frameOk && isWrite
     && addr == ADDR_OUTPUT_STATE)
    |=> (state_q.applied == $past(wData)) ##1 (switchOn == $past(wData)
        || !$past(enS)))
    else $error("transparent write not applied");

  AST_CRC_CHECK: assert property (
    (frameEnd && regS && crcS && !crcOk) |=> commErrorOutputOe)
    else $error("crc mismatch not flagged");

  AST_FAULT_PIN: assert property (
    ##1 (faultOe == $past(faultHit)))
    else $error("fault pin does not follow selected conditions");

  AST_COMM_ERR: assert property (
    badFrameSeq |=> commErrorOutputOe [*2])
    else $error("bad frame not flagged");

  AST_COMM_CLEAR: assert property (
    (frameEnd && frameOk && regS) |=> !commErrorOutputOe)
    else $error("good frame left comm error set");

  AST_READY: assert property (
    (state_q.logicOkSync[1] && state_q.ioOkSync[1] && regS)
    |=> !readyOe)
    else $error("ready not low with supplies good");

  AST_REG_POR: assert property (
    !regS |=> (state_q.outState == RST_OUTPUT_STATE
               && state_q.faultSel == RST_FAULT_SELECT && readyOe))
    else $error("register supply loss did not restore registers");

  AST_EN_PRIORITY: assert property (
    (!enS && strobeRise) |=> (switchOn == '0) [*2])
    else $error("strobe overrode enable low");

  AST_EDGE_PULSE: assert property (
    strobeRise |=> !strobeRise)
    else $error("strobe edge event longer than one cycle");

  AST_SWITCH_FOLLOW: assert property (
    enS |=> (switchOn == state_q.applied))
    else $error("switch outputs do not follow applied state");

  AST_OE_PAIR: assert property (
    (switchOn & ~switchOe) == '0)
    else $error("switch driven on while its driver is off");

  AST_TX_KEEP: assert property (
    badFrameSeq |=> $stable(state_q.txWord))
    else $error("refused frame changed the answer word");

  AST_CRC_GEN: assert property (
    (frameEnd && frameOk && regS && crcS)
    |=> (state_q.txWord[7:0] == crc8(state_q.txWord[LINK_W-1:8])))
    else $error("answer word carries a wrong crc");

endmodule : hs_switch_ctrl

`default_nettype wire

/* sim/spi_host_model.sv */
// serial host model: drives csN, spiClk and mosi one frame at a time
// assumes: the device shifts misoOut after each rising spiClk edge
`timescale 1ns/1ns
`default_nettype none

module spi_host_model (
  output logic spiClk,
  output logic csN,
  output logic mosi,
  input wire logic misoOut
);
  logic [23:0] rx;

  // clock stands low between frames, data line rests at its pulldown
  initial begin
    spiClk = 1'b0;
    csN = 1'b1;
    mosi = 1'b0;
    rx = 24'h000000;
  end

  // own crc so a wrong device polynomial cannot hide behind a shared one
  function automatic logic [7:0] hcrc(input logic [15:0] h);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ h[i]) ? 8'h07 : 8'h00);
    end
    return c;
  endfunction : hcrc

  // 125 ns bit period; 250 ns deselect keeps above the 200 ns gap
  task automatic xfer(input logic [23:0] w, input int n);
    rx = 24'h000000;
    csN = 1'b0;
    #62;
    for (int i = 0; i < n; i++) begin
      mosi = w[23-i];
      #62;
      // take the bit while it stands, before this edge moves it on
      rx = {rx[22:0], misoOut};
      spiClk = 1'b1;
      #63 spiClk = 1'b0;
    end
    #62 csN = 1'b1;
    mosi = 1'b0;
    #250;
  endtask : xfer
endmodule : spi_host_model

`default_nettype wire

/* sim/hs_switch_ctrl_tb_top.sv */
// self-checking bench for the switch control pins and serial link
// assumes: host model owns csN, spiClk, mosi; the bench owns other pins
`timescale 1ns/1ns
`default_nettype none

module hs_switch_ctrl_tb_top;
  typedef struct {int sel; logic [23:0] v;} note_t;
  logic core_clk, srst, spiClk, csN, mosi, misoOut, misoOe;
  logic enableIn, updateStrobe, crcSelectInput, crcOn;
  logic logicSupplyOk, ioSupplyOk, regSupplyOk, faultOe;
  logic commErrorOutputOe, readyOe;
  logic [7:0] faultConditions, switchOn, switchOe, a, b, c, d, s, f;
  int errors, comparisons, cycles;
  note_t q[$];
  event probeEv;
  string nm[5] = '{"switchOn", "switchOe", "faultOe", "commErr", "ready"};

  hs_switch_ctrl DUT (.core_clk(core_clk), .srst(srst), .spiClk(spiClk),
    .csN(csN), .mosi(mosi), .misoOut(misoOut), .misoOe(misoOe),
    .enableIn(enableIn), .updateStrobe(updateStrobe),
    .crcSelectInput(crcSelectInput), .logicSupplyOk(logicSupplyOk),
    .ioSupplyOk(ioSupplyOk), .regSupplyOk(regSupplyOk),
    .faultConditions(faultConditions), .switchOn(switchOn),
    .switchOe(switchOe), .faultOe(faultOe),
    .commErrorOutputOe(commErrorOutputOe), .readyOe(readyOe));
  spi_host_model host (.spiClk(spiClk), .csN(csN), .mosi(mosi),
    .misoOut(misoOut));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

///////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      test_done();
    end
  end

  // the serial output must be driven for every clock of a frame
  always @(posedge spiClk) begin
    cmpPin("misoOe", 8'h01, {7'h00, misoOe});
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask : tick

  task automatic note(input int sel, input logic [23:0] v);
    q.push_back('{sel, v});
  endtask : note

  // probe lets the watcher run before any input moves again
  task automatic probe();
    ->probeEv;
    tick(1);
  endtask : probe

  task automatic endT(input string t);
    probe();
    $display("test %s done", t);
  endtask : endT

  task automatic frm(input logic [15:0] h, input int n, input logic bad);
    logic [7:0] k;
    k = crcOn ? host.hcrc(h) ^ {8{bad}} : 8'h00;
    host.xfer({h, k}, n);
    tick(8);
  endtask : frm

  task automatic cmpPin(input string n, input logic [7:0] e, g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : cmpPin

  task automatic cmpWord(input logic [23:0] e, g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("BAD rxWord expected %h seen %h", e, g);
    end
  endtask : cmpWord

  function automatic logic [7:0] pinVal(input int k);
    case (k)
      0: return switchOn;
      1: return switchOe;
      2: return {7'h00, faultOe};
      3: return {7'h00, commErrorOutputOe};
      default: return {7'h00, readyOe};
    endcase
  endfunction : pinVal

  initial begin
    note_t x;
    forever begin
      @(probeEv);
      while (q.size() > 0) begin
        x = q.pop_front();
        if (x.sel == 5) begin
          cmpWord(x.v, host.rx);
        end else begin
          cmpPin(nm[x.sel], x.v[7:0], pinVal(x.sel));
        end
      end
    end
  end

///////////////////////////////////////////////////////////////////////////////
  initial begin
    srst = 1'b1;
    enableIn = 1'b1;
    updateStrobe = 1'b0;
    crcSelectInput = 1'b0;
    crcOn = 1'b0;
    logicSupplyOk = 1'b1;
    ioSupplyOk = 1'b1;
    regSupplyOk = 1'b1;
    faultConditions = 8'h00;
    void'($urandom(82163));
    tick(16);
    srst = 1'b0;
    tick(8);
    frm(16'h0300, 16, 1'b0);
    frm(16'h0000, 16, 1'b0);
    note(5, 24'h0003FF);
    note(2, 24'h0);
    note(4, 24'h0);
    note(3, 24'h0);
    cmpPin("misoOe", 8'h00, {7'h00, misoOe});
    endT("reset");
    a = 8'($urandom_range(255, 1));
    b = a ^ 8'hFF;
    c = a ^ 8'h0F;
    frm({8'h80, a}, 16, 1'b0);
    note(5, 24'h0);
    note(0, 24'h0);
    endT("hold");
    updateStrobe = 1'b1;
    tick(8);
    note(0, {16'h0, a});
    endT("edge");
    frm({8'h80, b}, 16, 1'b0);
    note(5, {16'h0080, a});
    note(0, {16'h0, b});
    endT("transparent");
    updateStrobe = 1'b0;
    tick(4);
    frm({8'h80, c}, 16, 1'b0);
    note(0, {16'h0, b});
    endT("low");
    enableIn = 1'b0;
    updateStrobe = 1'b1;
    tick(8);
    note(0, 24'h0);
    note(1, 24'h0);
    endT("disable");
    enableIn = 1'b1;
    tick(8);
    note(0, {16'h0, c});
    note(1, 24'hFF);
    endT("enable");
    updateStrobe = 1'b0;
    for (int i = 0; i < 4; i++) begin
      f = 8'($urandom);
      s = (i == 0) ? ~f : 8'($urandom);
      faultConditions = f;
      frm({8'h83, s}, 16, 1'b0);
      note(2, {23'h0, |(s & f)});
      endT("fault");
    end
    frm(16'h0000, 15, 1'b0);
    note(3, 24'h1);
    endT("short");
    frm(16'h0000, 16, 1'b0);
    note(3, 24'h0);
    note(5, {16'h0083, s});
    endT("recover");
    crcOn = 1'b1;
    crcSelectInput = 1'b1;
    tick(4);
    d = 8'($urandom);
    frm({8'h80, d}, 24, 1'b0);
    note(5, {8'h00, c, 8'h00});
    note(3, 24'h0);
    endT("crc good");
    frm({8'h80, ~d}, 24, 1'b1);
    note(3, 24'h1);
    endT("crc bad");
    frm(16'h0000, 24, 1'b0);
    frm(16'h0000, 24, 1'b0);
    note(5, {8'h00, d, host.hcrc({8'h00, d})});
    note(3, 24'h0);
    endT("crc read");
    crcOn = 1'b0;
    crcSelectInput = 1'b0;
    ioSupplyOk = 1'b0;
    tick(8);
    note(4, 24'h1);
    endT("io low");
    ioSupplyOk = 1'b1;
    logicSupplyOk = 1'b0;
    tick(8);
    note(4, 24'h1);
    endT("logic low");
    logicSupplyOk = 1'b1;
    regSupplyOk = 1'b0;
    tick(8);
    note(4, 24'h1);
    note(0, 24'h0);
    endT("reg low");
    regSupplyOk = 1'b1;
    tick(8);
    note(4, 24'h0);
    endT("reg back");
    frm(16'h0000, 15, 1'b0);
    note(3, 24'h1);
    probe();
    srst = 1'b1;
    tick(4);
    srst = 1'b0;
    tick(8);
    note(3, 24'h0);
    note(1, 24'hFF);
    note(4, 24'h0);
    endT("reset again");
    frm(16'h0000, 16, 1'b0);
    frm(16'h0300, 16, 1'b0);
    note(5, 24'h0);
    probe();
    frm(16'h0400, 16, 1'b0);
    note(5, 24'h0003FF);
    probe();
    frm(16'h0100, 16, 1'b0);
    note(5, 24'h000408);
    probe();
    frm(16'h0200, 16, 1'b0);
    note(5, 24'h000100);
    probe();
    frm(16'h0000, 16, 1'b0);
    note(5, {16'h0002, f});
    endT("power on");
    test_done();
  end
endmodule : hs_switch_ctrl_tb_top

`default_nettype wire
